// >>> logic/wdc_counter.sv
// slow oscillator counter with prescaled time-out detection
// assumes i_osc_tick is a one-cycle pulse per slow oscillator cycle
`timescale 1ns/10ps
`default_nettype none
module wdc_counter
  import wdc_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  input  wire logic                i_run,
  input  wire logic                i_restart,
  input  wire logic                i_osc_tick,
  input  wire logic [WDC_PS_W-1:0] i_prescale,
  output logic                     o_timeout
);
  logic [WDC_CNT_W-1:0] count_reg;
  logic [WDC_CNT_W-1:0] limit;
  logic [WDC_PS_W-1:0]  code;

  // reserved codes clamp to the longest period
  assign code  = (i_prescale > WDC_PS_MAX) ? WDC_PS_MAX : i_prescale;
  assign limit = WDC_CNT_W'(({{(WDC_CNT_W-1){1'b0}}, 1'b1} << (WDC_BASE_SHIFT + int'(code))) - 1);

  // tick counter, restarted by software or on time-out
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || i_restart || !i_run) begin
      count_reg <= '0;
    end else if (i_osc_tick) begin
      if (count_reg >= limit) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  // one-cycle time-out pulse at the selected count
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_timeout <= 1'b0;
    end else begin
      o_timeout <= i_run && !i_restart && i_osc_tick && (count_reg >= limit);
    end
  end

  // restart zeroes the count
  AST_RESTART: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_restart |=> count_reg == '0)
    else $error("restart did not clear count");

  // a time-out leaves the count wrapped to zero
  AST_TO_WRAP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_timeout |-> count_reg == '0)
    else $error("count not wrapped");
endmodule : wdc_counter
`default_nettype wire

// >>> logic/wdc_pkg.sv
// package of constants for the watchdog control and timeout block
// assumes a 10 MHz system clock and a slow oscillator tick input
//
// Behaviour
// - time-out flag, bit 7, sets on time-out in interrupt-capable mode
// - vectoring to the handler clears the time-out flag
// - writing one clears the time-out flag; zero leaves it
// - interrupt requested only when flag, enable bit 6 and global enable set
// - unprogrammed fuse: mode decoded from reset enable and interrupt enable
// - both enables set gives interrupt-then-reset mode
// - combined mode: first time-out only sets flag and interrupts
// - combined mode: vectoring clears interrupt enable and flag
// - combined mode: unserviced flag at next time-out causes reset
// - programmed fuse forces reset mode regardless of enables
// - clearing reset enable or changing prescale needs change enable
// - change enable clears itself four clocks after being written
// - reset enable reads one while reset-cause flag is set
// - prescale top bit in bit 5, lower bits in 2:0
// - codes 0 to 9 select 2048 up to 1048576 oscillator cycles
// - programmed fuse holds reset enable one and interrupt enable zero
// - counter counts slow oscillator ticks; restart instruction zeroes it
package wdc_pkg;
  localparam int         WDC_DATA_W      = 8;
  localparam int         WDC_ADDR_W      = 8;
  localparam logic [7:0] WDC_CTRL_ADDR   = 8'h00;
  localparam int         WDC_BIT_FLAG    = 7;
  localparam int         WDC_BIT_IE      = 6;
  localparam int         WDC_BIT_PS3     = 5;
  localparam int         WDC_BIT_CE      = 4;
  localparam int         WDC_BIT_RE      = 3;
  localparam int         WDC_PS_W        = 4;
  localparam int         WDC_CNT_W       = 21;
  localparam int         WDC_BASE_SHIFT  = 11;   // 2048 cycles at code 0
  localparam logic [3:0] WDC_PS_MAX      = 4'h9;
  localparam int         WDC_CE_CYCLES   = 4;
  localparam logic [2:0] WDC_CE_LOAD     = 3'(WDC_CE_CYCLES);
  localparam logic [3:0] WDC_PS_RESET    = 4'h0;
  typedef enum logic [1:0] {
    WDC_STOPPED,
    WDC_IRQ_MODE,
    WDC_RESET_MODE,
    WDC_COMBINED
  } wdc_mode_e;
endpackage : wdc_pkg

// >>> logic/wdc_watchdog_ctrl.sv
// control and status register of the watchdog with mode decode
// assumes a plain register port and a processor that acknowledges vectoring
`timescale 1ns/10ps
`default_nettype none

// register layout, one byte at the control address:
//   bit 7    time-out flag, write one to clear
//   bit 6    time-out interrupt enable
//   bit 5    prescale select top bit
//   bit 4    change enable, self clearing
//   bit 3    system reset enable
//   bits 2:0 prescale select low bits
// hazard: a shorter prescale can time out at once, so restart first
module wdc_watchdog_ctrl
  import wdc_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic [WDC_ADDR_W-1:0] i_addr,
  input  wire logic [WDC_DATA_W-1:0] i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [WDC_DATA_W-1:0] o_rdata,
  input  wire logic                  i_global_irq_enable,
  input  wire logic                  i_irq_vector_ack,
  input  wire logic                  i_watchdog_reset_cause_flag,
  input  wire logic                  i_always_on_fuse,
  input  wire logic                  i_wdr,
  input  wire logic                  i_osc_tick,
  output logic                       o_irq,
  output logic                       o_system_reset,
  output logic      [1:0]            o_mode
);
  logic                timeout_flag_reg;
  logic                timeout_irq_enable_reg;
  logic                system_reset_enable_reg;
  logic                change_enable_reg;
  logic [2:0]          ce_count_reg;
  logic [WDC_PS_W-1:0] prescale_select_reg;
  logic                sys_reset_reg;
  logic                ctrl_wr;
  logic                ctrl_rd;
  logic                fuse_on;
  logic                re_eff;
  logic                ie_eff;
  logic                timeout;
  logic                run;
  logic                flag_clr_wr;
  logic                set_flag;
  logic                ce_was;
  wdc_mode_e           mode;
  logic [WDC_PS_W-1:0] ps_wr;
  logic [2:0]          ce_age_reg;

  // decode of the single control register
  always_comb begin
    if (i_addr == WDC_CTRL_ADDR) begin
      ctrl_wr = i_wr;
      ctrl_rd = i_rd;
    end else begin
      ctrl_wr = 1'b0;
      ctrl_rd = 1'b0;
    end
  end

  assign ps_wr   = {i_wdata[WDC_BIT_PS3], i_wdata[2:0]};
  assign fuse_on = !i_always_on_fuse; // zero means programmed
  assign ce_was  = change_enable_reg;
  // effective enables under fuse and reset-cause overrides
  assign re_eff  = fuse_on || system_reset_enable_reg || i_watchdog_reset_cause_flag;
  assign ie_eff  = !fuse_on && timeout_irq_enable_reg;

  // mode decode from the enables
  always_comb begin
    if (fuse_on) begin
      mode = WDC_RESET_MODE;
    end else begin
      case ({re_eff, ie_eff})
        2'b00:   mode = WDC_STOPPED;
        2'b01:   mode = WDC_IRQ_MODE;
        2'b10:   mode = WDC_RESET_MODE;
        default: mode = WDC_COMBINED;
      endcase
    end
  end
  assign o_mode = mode;
  assign run    = (mode != WDC_STOPPED);

  wdc_counter u_counter (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .i_run      (run),
    .i_restart  (i_wdr),
    .i_osc_tick (i_osc_tick),
    .i_prescale (prescale_select_reg),
    .o_timeout  (timeout)
  );

  // flag sets on every time-out in interrupt mode, on the first time-out only in combined mode
  assign set_flag    = timeout && (mode == WDC_IRQ_MODE || mode == WDC_COMBINED)
                       && !(mode == WDC_COMBINED && timeout_flag_reg);
  assign flag_clr_wr = ctrl_wr && i_wdata[WDC_BIT_FLAG];

  // time-out flag: set wins over software and vector clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      timeout_flag_reg <= 1'b0;
    end else if (set_flag) begin
      timeout_flag_reg <= 1'b1;
    end else if (i_irq_vector_ack || flag_clr_wr) begin
      timeout_flag_reg <= 1'b0;
    end
  end

  // interrupt enable, cleared by vectoring in combined mode
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      timeout_irq_enable_reg <= 1'b0;
    end else if (ctrl_wr) begin
      timeout_irq_enable_reg <= i_wdata[WDC_BIT_IE];
    end else if (i_irq_vector_ack && mode == WDC_COMBINED) begin
      timeout_irq_enable_reg <= 1'b0;
    end
  end

  // reset enable: set freely, cleared only under change enable
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      system_reset_enable_reg <= 1'b0;
    end else if (ctrl_wr) begin
      if (i_wdata[WDC_BIT_RE]) begin
        system_reset_enable_reg <= 1'b1;
      end else if (ce_was && !i_watchdog_reset_cause_flag) begin
        system_reset_enable_reg <= 1'b0;
      end
    end
  end

  // prescale changes only under change enable
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prescale_select_reg <= WDC_PS_RESET;
    end else if (ctrl_wr && ce_was) begin
      prescale_select_reg <= ps_wr;
    end
  end

  // change enable with four-cycle self clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      change_enable_reg <= 1'b0;
      ce_count_reg      <= 3'h0;
    end else if (ctrl_wr && i_wdata[WDC_BIT_CE] && i_wdata[WDC_BIT_RE]) begin
      change_enable_reg <= 1'b1;
      ce_count_reg      <= WDC_CE_LOAD;
    end else if (ctrl_wr) begin
      change_enable_reg <= 1'b0;
      ce_count_reg      <= 3'h0;
    end else if (ce_count_reg != 3'h0) begin
      ce_count_reg      <= ce_count_reg - 3'h1;
      change_enable_reg <= (ce_count_reg != 3'h1);
    end
  end

  // system reset pulse on time-out in reset mode, or in combined mode while the flag stands
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sys_reset_reg <= 1'b0;
    end else begin
      sys_reset_reg <= timeout && (mode == WDC_RESET_MODE
                       || (mode == WDC_COMBINED && timeout_flag_reg));
    end
  end
  assign o_system_reset = sys_reset_reg;

  // interrupt request gated by enable and global enable
  assign o_irq = timeout_flag_reg && ie_eff && i_global_irq_enable;

  // read data one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (ctrl_rd) begin
      o_rdata <= {timeout_flag_reg, ie_eff, prescale_select_reg[3], change_enable_reg,
                  re_eff, prescale_select_reg[2:0]};
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // age of the change enable window, helper for its self clear check
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ce_age_reg <= 3'h0;
    end else if (!change_enable_reg || ctrl_wr) begin
      ce_age_reg <= 3'h0;
    end else if (ce_age_reg != 3'h7) begin
      ce_age_reg <= ce_age_reg + 3'h1;
    end
  end

  // flag sets on a qualifying time-out
  AST_FLAG_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    set_flag |=> timeout_flag_reg)
    else $error("flag not set");

  // write one clears the flag
  AST_W1C: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    flag_clr_wr && !set_flag |=> !timeout_flag_reg)
    else $error("flag not cleared");

  // write zero keeps the flag
  AST_FLAG_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_wr && !i_wdata[WDC_BIT_FLAG] && timeout_flag_reg && !i_irq_vector_ack
    |=> timeout_flag_reg)
    else $error("flag lost on zero write");

  // vectoring clears the flag
  AST_FLAG_ACK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_irq_vector_ack && !set_flag |=> !timeout_flag_reg)
    else $error("vector did not clear flag");

  // request only with flag, global enable and unprogrammed fuse
  AST_IRQ: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_irq |-> timeout_flag_reg && i_global_irq_enable && !fuse_on)
    else $error("bad irq");

  // request raised whenever flag and both enables stand
  AST_IRQ_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    timeout_flag_reg && ie_eff && i_global_irq_enable |-> o_irq)
    else $error("irq missing");

  // stopped decode
  AST_MODE_STOP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !fuse_on && !re_eff && !ie_eff |-> mode == WDC_STOPPED)
    else $error("not stopped");

  // interrupt decode
  AST_MODE_IRQ: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !fuse_on && !re_eff && ie_eff |-> mode == WDC_IRQ_MODE)
    else $error("not interrupt mode");

  // stopped counter never times out
  AST_STOP_QUIET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    mode == WDC_STOPPED |=> !timeout)
    else $error("time-out while stopped");

  // interrupt mode never resets the system
  AST_IRQ_NO_RST: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    timeout && mode == WDC_IRQ_MODE |=> !o_system_reset)
    else $error("reset in interrupt mode");

  // combined decode
  AST_MODE_COMB: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !fuse_on && re_eff && ie_eff |-> mode == WDC_COMBINED)
    else $error("not combined mode");

  // first combined time-out only flags
  AST_FIRST_TO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    timeout && mode == WDC_COMBINED && !timeout_flag_reg
    |=> timeout_flag_reg && !o_system_reset)
    else $error("first time-out misbehaved");

  // self clear of change enable
  AST_CE_SELF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(change_enable_reg) ##1 !ctrl_wr [*4] |-> !change_enable_reg)
    else $error("ce stuck");

  // change enable never outlives its window
  AST_CE_AGE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    change_enable_reg |-> ce_age_reg < 3'(WDC_CE_CYCLES))
    else $error("ce window too long");

  // any other write closes the window
  AST_CE_WR_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_wr && !(i_wdata[WDC_BIT_CE] && i_wdata[WDC_BIT_RE]) |=> !change_enable_reg)
    else $error("ce kept after write");

  // reset-cause flag forces the enable
  AST_RE_CAUSE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_watchdog_reset_cause_flag |-> re_eff)
    else $error("re not forced");

  // reset enable kept while the cause flag stands
  AST_RE_CAUSE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_watchdog_reset_cause_flag && system_reset_enable_reg |=> system_reset_enable_reg)
    else $error("re cleared under cause");

  // readback shows the forced enable
  AST_RDATA_RE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_rd && i_watchdog_reset_cause_flag |=> o_rdata[WDC_BIT_RE])
    else $error("re not read as one");

  // prescale locked without change enable
  AST_PS_LOCK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_wr && !ce_was |=> $stable(prescale_select_reg))
    else $error("ps changed");

  // reset enable not cleared without change enable
  AST_RE_LOCK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_wr && !ce_was && system_reset_enable_reg |=> system_reset_enable_reg)
    else $error("re cleared unlocked");

  // reset enable may always be set
  AST_RE_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_wr && i_wdata[WDC_BIT_RE] |=> system_reset_enable_reg)
    else $error("re not set");

  // prescale field gathered from bit 5 and bits 2:0
  AST_PS_SPLIT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_wr && ce_was
    |=> prescale_select_reg == {$past(i_wdata[WDC_BIT_PS3]), $past(i_wdata[2:0])})
    else $error("ps split wrong");

  // programmed fuse forces reset mode
  AST_FUSE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    fuse_on |-> mode == WDC_RESET_MODE && !o_irq)
    else $error("fuse ignored");

  // programmed fuse pins the enables
  AST_FUSE_FIELDS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    fuse_on |-> re_eff && !ie_eff)
    else $error("fuse enables wrong");

  // reset mode resets on time-out
  AST_RST_MODE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    timeout && mode == WDC_RESET_MODE |=> o_system_reset)
    else $error("no reset in reset mode");

  // reset is a single pulse
  AST_RST_PULSE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_system_reset |=> !o_system_reset)
    else $error("reset pulse too long");

  // unserviced combined time-out resets
  AST_COMB_RST: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    timeout && mode == WDC_COMBINED && timeout_flag_reg |=> o_system_reset)
    else $error("no reset");

  // vectoring in combined mode drops to reset mode
  AST_COMB_ACK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_irq_vector_ack && mode == WDC_COMBINED && !ctrl_wr && !set_flag
    |=> !timeout_irq_enable_reg && !timeout_flag_reg)
    else $error("ack no clear");
endmodule : wdc_watchdog_ctrl
`default_nettype wire

// >>> verif/tb_watchdog_control_and_timeout.sv
// bench for the watchdog control register, mode decode and time-out
// assumes the slow tick runs every clock, so code 0 times out in 2048 clocks
`timescale 1ns/10ps
`default_nettype none
module tb_watchdog_control_and_timeout;
  import wdc_pkg::*;
  logic       i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, rv, o_rdata;
  logic       i_global_irq_enable = 1'b1, i_irq_vector_ack = 1'b0, i_wdr = 1'b0;
  logic       i_watchdog_reset_cause_flag = 1'b0, i_always_on_fuse = 1'b1;
  logic       i_osc_tick = 1'b1, o_irq, o_system_reset;
  logic [1:0] o_mode;
  logic [3:0] p;
  int         fails = 0, n_compared = 0, n_rst = 0, r0 = 0, cyc = 0;

  wdc_watchdog_ctrl dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_global_irq_enable(i_global_irq_enable), .i_irq_vector_ack(i_irq_vector_ack),
    .i_watchdog_reset_cause_flag(i_watchdog_reset_cause_flag),
    .i_always_on_fuse(i_always_on_fuse), .i_wdr(i_wdr), .i_osc_tick(i_osc_tick),
    .o_irq(o_irq), .o_system_reset(o_system_reset), .o_mode(o_mode));

  // clock, reset pulse count and hang guard
  always #50 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    cyc++;
    if (o_system_reset === 1'b1) n_rst++;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end

  function automatic logic [7:0] reg_of(input logic [3:0] ps, input logic ie, input logic re);
    return {1'b0, ie, ps[3], 1'b0, re, ps[2:0]};
  endfunction : reg_of

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // one-cycle register strobes, read data taken the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask : rd
  // timed sequence: change enable with reset enable, then the value
  task automatic set_ctrl(input logic [7:0] v);
    wr(8'h00, 8'h18);
    wr(8'h00, v);
  endtask : set_ctrl
  // one-cycle pulse of restart or vector acknowledge
  task automatic kick(input bit ack);
    @(posedge i_clk);
    if (ack) i_irq_vector_ack <= 1'b1;
    else i_wdr <= 1'b1;
    @(posedge i_clk);
    i_irq_vector_ack <= 1'b0;
    i_wdr            <= 1'b0;
  endtask : kick
  task automatic wait_irq;
    for (int n = 0; n < 2300 && o_irq !== 1'b1; n++) @(negedge i_clk);
  endtask : wait_irq

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    void'($urandom(32'hb76bcd6f));
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(8'h00);
    chk(rv, 8'h00, "reset value");
    wr(8'h3c, 8'hff);
    rd(8'h3c);
    chk(rv, 8'h00, "unmapped read");
    $display("test done: reset and map");
    wr(8'h00, 8'h0d);
    rd(8'h00);
    chk(rv, 8'h08, "prescale without change enable");
    wr(8'h00, 8'h00);
    rd(8'h00);
    chk(rv, 8'h08, "clear without change enable");
    wr(8'h00, 8'h18);
    repeat (6) @(posedge i_clk);
    wr(8'h00, 8'h00);
    rd(8'h00);
    chk(rv, 8'h08, "change enable expired");
    for (int k = 0; k < 10; k++) begin
      p = (k < 2) ? 4'(k * 9) : 4'($urandom_range(9, 0));
      set_ctrl(reg_of(p, 1'b0, 1'b1));
      rd(8'h00);
      chk(rv, reg_of(p, 1'b0, 1'b1), "prescale split");
    end
    $display("test done: timed sequence");
    for (int m = 0; m < 8; m++) begin
      @(posedge i_clk);
      i_always_on_fuse <= ~m[2];
      set_ctrl(reg_of(4'h0, m[0], m[1]));
      @(negedge i_clk);
      chk({6'h0, o_mode}, m[2] ? 8'h02 : 8'(m[1:0]), "mode");
      rd(8'h00);
      if (m[2]) chk({6'h0, rv[6], rv[3]}, 8'h01, "fuse locks");
    end
    @(posedge i_clk);
    i_always_on_fuse            <= 1'b1;
    i_watchdog_reset_cause_flag <= 1'b1;
    set_ctrl(8'h00);
    rd(8'h00);
    chk({4'h0, rv[3:0]}, 8'h08, "cause holds reset enable");
    @(posedge i_clk);
    i_watchdog_reset_cause_flag <= 1'b0;
    set_ctrl(8'h80);
    rd(8'h00);
    chk(rv, 8'h00, "cleared after cause");
    $display("test done: modes");
    set_ctrl(8'h40);
    kick(1'b0);
    repeat (1500) @(posedge i_clk);
    kick(1'b0);
    repeat (1000) @(posedge i_clk);
    chk({7'h0, o_irq}, 8'h00, "restart delays time-out");
    r0 = n_rst;
    wait_irq();
    chk({7'h0, o_irq}, 8'h01, "time-out interrupt");
    rd(8'h00);
    chk(rv, 8'hc0, "flag set");
    @(posedge i_clk);
    i_global_irq_enable <= 1'b0;
    @(negedge i_clk);
    chk({7'h0, o_irq}, 8'h00, "global mask");
    @(posedge i_clk);
    i_global_irq_enable <= 1'b1;
    wr(8'h00, 8'h40);
    rd(8'h00);
    chk(rv, 8'hc0, "zero keeps flag");
    wr(8'h00, 8'hc0);
    rd(8'h00);
    chk(rv, 8'h40, "one clears flag");
    wait_irq();
    chk({7'h0, o_irq}, 8'h01, "second time-out");
    kick(1'b1);
    rd(8'h00);
    chk(rv, 8'h40, "vector clears flag");
    chk(8'(n_rst - r0), 8'h00, "no reset in interrupt mode");
    $display("test done: interrupt mode");
    set_ctrl(8'h48);
    kick(1'b0);
    r0 = n_rst;
    wait_irq();
    chk({7'h0, o_irq}, 8'h01, "combined first time-out");
    chk(8'(n_rst - r0), 8'h00, "no reset at first time-out");
    kick(1'b1);
    rd(8'h00);
    chk(rv, 8'h08, "vector drops enable and flag");
    wr(8'h00, 8'h48);
    kick(1'b0);
    wait_irq();
    chk({7'h0, o_irq}, 8'h01, "re-enabled interrupt");
    for (int n = 0; n < 2300 && n_rst == r0; n++) @(negedge i_clk);
    chk(8'(n_rst - r0), 8'h01, "unserviced time-out resets");
    $display("test done: combined mode");
    @(posedge i_clk);
    i_always_on_fuse <= 1'b0;
    kick(1'b0);
    r0 = n_rst;
    repeat (2060) @(negedge i_clk);
    chk(8'(n_rst - r0), 8'h01, "fuse forces reset mode");
    chk({7'h0, o_irq}, 8'h00, "fuse masks interrupt");
    $display("test done: fuse mode");
    end_sim();
  end
endmodule : tb_watchdog_control_and_timeout
`default_nettype wire
